// File: ccpp_defines.vh
// constants shared by the capture/compare port pin logic
`ifndef CCPP_DEFINES_VH
`define CCPP_DEFINES_VH

// register indices; the bus byte address is four times the index
`define CCPP_IDX_P2_DATA    16'hffc0
`define CCPP_IDX_P2_DIR     16'hffc2
`define CCPP_IDX_P2_OD      16'hf1c2
`define CCPP_IDX_P3_DATA    16'hffc4
`define CCPP_IDX_P3_DIR     16'hffc6
`define CCPP_IDX_P3_OD      16'hf1c6
`define CCPP_IDX_P2_PIN     16'h0100
`define CCPP_IDX_P3_PIN     16'h0101

// internal register select codes
`define CCPP_SEL_NONE       4'h0
`define CCPP_SEL_P2_DATA    4'h1
`define CCPP_SEL_P2_DIR     4'h2
`define CCPP_SEL_P2_OD      4'h3
`define CCPP_SEL_P3_DATA    4'h4
`define CCPP_SEL_P3_DIR     4'h5
`define CCPP_SEL_P3_OD      4'h6
`define CCPP_SEL_P2_PIN     4'h7
`define CCPP_SEL_P3_PIN     4'h8

// reset values and implemented-bit masks
`define CCPP_RESET_VALUE    16'h0000
`define CCPP_P2_MASK        16'hffff
`define CCPP_P3_DATA_MASK   16'hbfff
`define CCPP_P3_DIR_MASK    16'hbfff
`define CCPP_P3_OD_MASK     16'h2fff
`define CCPP_P3_PIN_MASK    16'hbfff

// field positions
`define CCPP_HI_LSB         8
`define CCPP_HI_MSB         15
`define CCPP_T7_BIT         15
`define CCPP_ALIGN_BITS     2'h0

// interrupt sampling, counted in system clock phases (two per pclk)
`define CCPP_SLOW_SAMPLE_TCL 16
`define CCPP_FAST_SAMPLE_TCL 2
`define CCPP_TCL_PER_CLK     2

`endif

// File: ccpp_sampler.v
// periodic pin sampler with edge pulse for external interrupt inputs
`default_nettype none
`include "ccpp_defines.vh"

module ccpp_sampler #(
   parameter WIDTH      = 8,
   parameter PERIOD_TCL = `CCPP_SLOW_SAMPLE_TCL
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [WIDTH-1:0] line_in,
   output reg  [WIDTH-1:0] level,
   output reg  [WIDTH-1:0] edge_pulse
);

   // sampling period in pclk cycles, never below one
   localparam CYCLES_RAW = PERIOD_TCL / `CCPP_TCL_PER_CLK;
   localparam CYCLES     = (CYCLES_RAW < 1) ? 1 : CYCLES_RAW;
   localparam [7:0] LAST = CYCLES - 1;

   reg  [7:0] phase_cnt;
   wire       tick;

   assign tick = (phase_cnt == LAST);

   // free running phase counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_cnt <= 8'h00;
      end else if (tick) begin
         phase_cnt <= 8'h00;
      end else begin
         phase_cnt <= phase_cnt + 8'h01;
      end
   end

   // pulses shorter than the period may be missed; that is the point of slow sampling
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level      <= {WIDTH{1'b0}};
         edge_pulse <= {WIDTH{1'b0}};
      end else if (tick) begin
         level      <= line_in;
         edge_pulse <= line_in ^ level;
      end else begin
         edge_pulse <= {WIDTH{1'b0}};
      end
   end

endmodule // ccpp_sampler
`default_nettype wire

// File: ccpp_port_pins.v
// pin logic of the capture/compare port and the general purpose third port
//
// Behaviour
// - each second-port line is a capture input or compare output, one channel each
// - upper eight second-port lines are interrupt inputs sampled every 16 clock phases
// - capture sees input latch; an output line shows its own output latch
// - compare mode 1 trigger inverts the output latch and writes it back
// - compare mode 3: match writes one, timer overflow writes zero, on trigger
// - the CPU can always write the output latch of a compare line
// - CPU write and compare trigger together: CPU value wins
// - the upper eight capture inputs also serve as fast interrupts sampled every 2 clock phases
// - fast interrupt sampling exists only on the upper eight lines
// - top second-port line is also the timer seven count input
// - a multiplexer merges bus data and alternate data before the output latch
// - third port has 15 usable lines with direction and mostly open-drain bits
// - third-port direction 0 is high-impedance input, 1 is output
// - third-port open-drain 0 is push/pull, 1 is open drain
// - third-port lines 15 and 12 have no open-drain bit
// - third-port data bit 14 drives no pin
// - each second-port line has direction and open-drain bits
//
// The APB slave port was left to the implementer.
`default_nettype none
`include "ccpp_defines.vh"

module ccpp_port_pins #(
   parameter ADDR_WIDTH = 18,
   parameter P_WIDTH    = 16,
   parameter HI_WIDTH   = 8
) (
   input  wire                  pclk,
   input  wire                  presetn,
   // apb slave
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [ADDR_WIDTH-1:0] paddr,
   input  wire [31:0]           pwdata,
   output reg  [31:0]           prdata,
   output wire                  pready,
   output wire                  pslverr,
   // second port pins
   input  wire [P_WIDTH-1:0]    p2_pin_in,
   output wire [P_WIDTH-1:0]    p2_pin_out,
   output wire [P_WIDTH-1:0]    p2_pin_oe,
   // third port pins
   input  wire [P_WIDTH-1:0]    p3_pin_in,
   output wire [P_WIDTH-1:0]    p3_pin_out,
   output wire [P_WIDTH-1:0]    p3_pin_oe,
   // first capture/compare unit side
   input  wire [P_WIDTH-1:0]    cc_trigger,
   input  wire [P_WIDTH-1:0]    cc_toggle_mode,
   input  wire [P_WIDTH-1:0]    cc_overflow,
   output reg  [P_WIDTH-1:0]    capture_compare_channel_pin,
   output wire [P_WIDTH-1:0]    cc_latch_data,
   // second capture/compare unit side
   output wire                  timer_seven_count_input,
   // interrupt sampling
   output wire [HI_WIDTH-1:0]   external_interrupt_input,
   output wire [HI_WIDTH-1:0]   external_interrupt_edge,
   output wire [HI_WIDTH-1:0]   fast_interrupt_input,
   output wire [HI_WIDTH-1:0]   fast_interrupt_edge
);

   // ------------------------------------------------------------------
   // register select decode, shared by the read and write paths
   // ------------------------------------------------------------------
   function [3:0] decode_sel;
      input [ADDR_WIDTH-1:0] addr;
      reg   [15:0]           idx;
      begin
         idx        = addr[ADDR_WIDTH-1:2];
         decode_sel = `CCPP_SEL_NONE;
         if (addr[1:0] == `CCPP_ALIGN_BITS) begin
            case (idx)
               `CCPP_IDX_P2_DATA: decode_sel = `CCPP_SEL_P2_DATA;
               `CCPP_IDX_P2_DIR:  decode_sel = `CCPP_SEL_P2_DIR;
               `CCPP_IDX_P2_OD:   decode_sel = `CCPP_SEL_P2_OD;
               `CCPP_IDX_P3_DATA: decode_sel = `CCPP_SEL_P3_DATA;
               `CCPP_IDX_P3_DIR:  decode_sel = `CCPP_SEL_P3_DIR;
               `CCPP_IDX_P3_OD:   decode_sel = `CCPP_SEL_P3_OD;
               `CCPP_IDX_P2_PIN:  decode_sel = `CCPP_SEL_P2_PIN;
               `CCPP_IDX_P3_PIN:  decode_sel = `CCPP_SEL_P3_PIN;
               default:           decode_sel = `CCPP_SEL_NONE;
            endcase
         end
      end
   endfunction

   // ------------------------------------------------------------------
   // pin driver: open drain releases the pin instead of driving a one
   // ------------------------------------------------------------------
   function [P_WIDTH-1:0] drive_enable;
      input [P_WIDTH-1:0] dir;
      input [P_WIDTH-1:0] od;
      input [P_WIDTH-1:0] latch;
      begin
         drive_enable = dir & (~od | ~latch);
      end
   endfunction

   reg  [P_WIDTH-1:0]  p2_latch;
   reg  [P_WIDTH-1:0]  p2_dir;
   reg  [P_WIDTH-1:0]  p2_od;
   reg  [P_WIDTH-1:0]  p3_latch;
   reg  [P_WIDTH-1:0]  p3_dir;
   reg  [P_WIDTH-1:0]  p3_od;
   reg  [P_WIDTH-1:0]  p2_meta;
   reg  [P_WIDTH-1:0]  p2_sync;
   reg  [P_WIDTH-1:0]  p3_meta;
   reg  [P_WIDTH-1:0]  p3_sync;
   reg  [P_WIDTH-1:0]  p3_in_latch;
   reg  [P_WIDTH-1:0]  next_p2_latch;
   reg  [P_WIDTH-1:0]  alt_data_out;
   reg  [31:0]         next_prdata;
   wire [3:0]          sel;
   wire                bus_write;
   wire                setup_phase;
   wire [P_WIDTH-1:0]  wdata16;
   integer             i;
   integer             j;

   // ------------------------------------------------------------------
   // apb decode; zero wait states, so pready is simply high
   // ------------------------------------------------------------------
   assign sel         = decode_sel(paddr);
   assign wdata16     = pwdata[P_WIDTH-1:0];
   assign bus_write   = psel & penable & pwrite & (sel != `CCPP_SEL_NONE);
   assign setup_phase = psel & ~penable;
   assign pready      = 1'b1;
   // unmapped or misaligned addresses and writes to read-only pin views fail
   assign pslverr     = psel & penable & ((sel == `CCPP_SEL_NONE) |
                        (pwrite & ((sel == `CCPP_SEL_P2_PIN) | (sel == `CCPP_SEL_P3_PIN))));

   // ------------------------------------------------------------------
   // two-stage synchronisers on both pin groups
   // ------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p2_meta <= `CCPP_RESET_VALUE;
         p2_sync <= `CCPP_RESET_VALUE;
         p3_meta <= `CCPP_RESET_VALUE;
         p3_sync <= `CCPP_RESET_VALUE;
      end else begin
         p2_meta <= p2_pin_in;
         p2_sync <= p2_meta;
         p3_meta <= p3_pin_in;
         p3_sync <= p3_meta;
      end
   end

   // ------------------------------------------------------------------
   // second port alternate data: toggle in mode 1, set/clear in mode 3
   // ------------------------------------------------------------------
   always @* begin
      for (i = 0; i < P_WIDTH; i = i + 1) begin
         if (cc_toggle_mode[i]) begin
            alt_data_out[i] = ~p2_latch[i];
         end else begin
            // overflow takes the zero, a plain match the one
            alt_data_out[i] = ~cc_overflow[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // output latch input multiplexer; a bus write to the second-port data register steers it to the bus
   // and any trigger in that cycle is dropped on purpose
   // ------------------------------------------------------------------
   always @* begin
      next_p2_latch = p2_latch;
      // own loop index so each combinational process drives only its own variables
      for (j = 0; j < P_WIDTH; j = j + 1) begin
         if (bus_write && (sel == `CCPP_SEL_P2_DATA)) begin
            next_p2_latch[j] = wdata16[j];
         end else if (cc_trigger[j]) begin
            next_p2_latch[j] = alt_data_out[j];
         end
      end
   end

   // ------------------------------------------------------------------
   // second port registers
   // ------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p2_latch <= `CCPP_RESET_VALUE;
         p2_dir   <= `CCPP_RESET_VALUE;
         p2_od    <= `CCPP_RESET_VALUE;
      end else begin
         p2_latch <= next_p2_latch;
         if (bus_write && (sel == `CCPP_SEL_P2_DIR)) begin
            p2_dir <= wdata16 & `CCPP_P2_MASK;
         end
         if (bus_write && (sel == `CCPP_SEL_P2_OD)) begin
            p2_od <= wdata16 & `CCPP_P2_MASK;
         end
      end
   end

   // ------------------------------------------------------------------
   // third port registers; absent bits are masked so they stay zero
   // ------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p3_latch <= `CCPP_RESET_VALUE;
         p3_dir   <= `CCPP_RESET_VALUE;
         p3_od    <= `CCPP_RESET_VALUE;
      end else begin
         if (bus_write && (sel == `CCPP_SEL_P3_DATA)) begin
            p3_latch <= wdata16 & `CCPP_P3_DATA_MASK;
         end
         if (bus_write && (sel == `CCPP_SEL_P3_DIR)) begin
            p3_dir <= wdata16 & `CCPP_P3_DIR_MASK;
         end
         if (bus_write && (sel == `CCPP_SEL_P3_OD)) begin
            p3_od <= wdata16 & `CCPP_P3_OD_MASK;
         end
      end
   end

   // ------------------------------------------------------------------
   // pin drivers; direction 0 floats the line, open drain only pulls low
   // ------------------------------------------------------------------
   assign p2_pin_out = p2_latch;
   assign p2_pin_oe  = drive_enable(p2_dir, p2_od, p2_latch);
   assign p3_pin_out = p3_latch & `CCPP_P3_PIN_MASK;
   // bit 14 never drives: mask keeps its enable low
   assign p3_pin_oe  = drive_enable(p3_dir, p3_od, p3_latch)
                       & `CCPP_P3_PIN_MASK;

   // ------------------------------------------------------------------
   // input latches; an output line reads back its own latch, so the
   // two-cycle pin delay does not blur a software-made capture
   // ------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_compare_channel_pin <= `CCPP_RESET_VALUE;
         p3_in_latch                 <= `CCPP_RESET_VALUE;
      end else begin
         capture_compare_channel_pin <= (p2_dir & p2_latch) |
                                        (~p2_dir & p2_sync);
         p3_in_latch <= ((p3_dir & p3_latch) | (~p3_dir & p3_sync))
                        & `CCPP_P3_PIN_MASK;
      end
   end

   // compare hardware reads the output latch back for toggling
   assign cc_latch_data = p2_latch;

   // timer seven counts from the top line's input latch
   assign timer_seven_count_input =
      capture_compare_channel_pin[`CCPP_T7_BIT];

   // ------------------------------------------------------------------
   // interrupt samplers on the upper eight lines only; slow one trades
   // latency for noise rejection, fast one sees every pclk
   // ------------------------------------------------------------------
   ccpp_sampler #(
      .WIDTH      (HI_WIDTH),
      .PERIOD_TCL (`CCPP_SLOW_SAMPLE_TCL)
   ) u_slow_sampler (
      .pclk       (pclk),
      .presetn    (presetn),
      .line_in    (capture_compare_channel_pin[`CCPP_HI_MSB:`CCPP_HI_LSB]),
      .level      (external_interrupt_input),
      .edge_pulse (external_interrupt_edge)
   );

   ccpp_sampler #(
      .WIDTH      (HI_WIDTH),
      .PERIOD_TCL (`CCPP_FAST_SAMPLE_TCL)
   ) u_fast_sampler (
      .pclk       (pclk),
      .presetn    (presetn),
      .line_in    (capture_compare_channel_pin[`CCPP_HI_MSB:`CCPP_HI_LSB]),
      .level      (fast_interrupt_input),
      .edge_pulse (fast_interrupt_edge)
   );

   // ------------------------------------------------------------------
   // read mux; upper sixteen data bits always read zero
   // ------------------------------------------------------------------
   always @* begin
      next_prdata = 32'h00000000;
      case (sel)
         `CCPP_SEL_P2_DATA: next_prdata[P_WIDTH-1:0] = p2_latch;
         `CCPP_SEL_P2_DIR:  next_prdata[P_WIDTH-1:0] = p2_dir;
         `CCPP_SEL_P2_OD:   next_prdata[P_WIDTH-1:0] = p2_od;
         `CCPP_SEL_P3_DATA: next_prdata[P_WIDTH-1:0] = p3_latch;
         `CCPP_SEL_P3_DIR:  next_prdata[P_WIDTH-1:0] = p3_dir & `CCPP_P3_DIR_MASK;
         `CCPP_SEL_P3_OD:   next_prdata[P_WIDTH-1:0] = p3_od & `CCPP_P3_OD_MASK;
         `CCPP_SEL_P2_PIN:  next_prdata[P_WIDTH-1:0] = capture_compare_channel_pin;
         `CCPP_SEL_P3_PIN:  next_prdata[P_WIDTH-1:0] = p3_in_latch;
         default:           next_prdata = 32'h00000000;
      endcase
   end

   // read data captured in the setup cycle so it comes from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup_phase && !pwrite) begin
         prdata <= next_prdata;
      end
   end

endmodule // ccpp_port_pins
`default_nettype wire

// File: ccpp_checker.sv
// assertions on the port pin block, seen from its ports only
`default_nettype none
module ccpp_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   input wire logic [15:0] p2_pin_out,
   input wire logic [15:0] p3_pin_out,
   input wire logic [15:0] p3_pin_oe,
   input wire logic [15:0] cc_trigger,
   input wire logic [15:0] cc_toggle_mode,
   input wire logic [15:0] cc_overflow,
   input wire logic [15:0] capture_compare_channel_pin,
   input wire logic        timer_seven_count_input,
   input wire logic [7:0]  external_interrupt_input,
   input wire logic [7:0]  fast_interrupt_input
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] tq, gq, vq, oq, dq, cq;
   logic        wq;
   logic [2:0]  cnt;
   wire         wr = psel & penable & pwrite & (paddr == 18'h3ff00);
   // copies of the cycle before; the latch is judged against its old value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {tq, gq, vq, oq, dq, cq} <= '0;
         wq  <= 1'b0;
         cnt <= 3'h0;
      end else begin
         tq  <= cc_trigger;
         gq  <= cc_toggle_mode;
         vq  <= cc_overflow;
         oq  <= p2_pin_out;
         dq  <= pwdata[15:0];
         cq  <= capture_compare_channel_pin;
         wq  <= wr;
         cnt <= cnt + 3'h1; // slow sampling lands when this wraps to zero
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_misaligned_error:
      assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access not refused");
   a_bit14_dead:
      assert property (p3_pin_out[14] == 1'b0 && p3_pin_oe[14] == 1'b0)
      else $error("third port line 14 active");
   a_timer7_follows:
      assert property (timer_seven_count_input == capture_compare_channel_pin[15])
      else $error("timer seven input differs from line 15");
   a_cpu_wins:
      assert property (wq |-> p2_pin_out == dq)
      else $error("bus write did not set latch");
   a_toggle_inverts:
      assert property (!wq |-> ((p2_pin_out ^ ~oq) & tq & gq) == 16'h0000)
      else $error("toggle compare did not invert");
   a_mode3_sets:
      assert property (!wq |-> ((p2_pin_out ^ ~vq) & tq & ~gq) == 16'h0000)
      else $error("set clear compare wrong");
   a_latch_holds:
      assert property (!wq |-> ((p2_pin_out ^ oq) & ~tq) == 16'h0000)
      else $error("latch changed without cause");
   a_fast_follows:
      assert property (fast_interrupt_input == cq[15:8])
      else $error("fast interrupt sample late");
   a_slow_period:
      assert property (cnt != 3'h0 |-> $stable(external_interrupt_input))
      else $error("slow interrupt sample off period");
endmodule // ccpp_checker
`default_nettype wire

// File: ccpp_partner.sv
// outside devices on one port: drive pins, pull nothing
`default_nettype none
module ccpp_partner (
   input  wire logic        pclk,
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe,
   input  wire logic [15:0] ext_en,
   input  wire logic [15:0] ext_val,
   output wire logic [15:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] last = 16'h0000;
   // outside drive gated by the port's enable so no fight occurs
   // a released undriven line flips each cycle, never looks like the latch
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & ~last);
   always @(posedge pclk) begin
      last <= pin_in;
   end
endmodule // ccpp_partner
`default_nettype wire

// File: capture_compare_port_pins_bench.sv
// self-checking bench for the port pin block with its outside-pin partners
`default_nettype none
`include "ccpp_defines.vh"
module capture_compare_port_pins_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] cc_trigger = 16'h0;
   logic [15:0] cc_toggle_mode = 16'h0;
   logic [15:0] cc_overflow = 16'h0;
   logic [15:0] e2_en = 16'h0;
   logic [15:0] e2_val = 16'h0;
   logic [15:0] e3_en = 16'h0;
   logic [15:0] e3_val = 16'h0;
   wire  [31:0] prdata;
   wire         pready, pslverr, timer_seven_count_input;
   wire  [15:0] p2_pin_in, p2_pin_out, p2_pin_oe, p3_pin_in, p3_pin_out, p3_pin_oe;
   wire  [15:0] capture_compare_channel_pin, cc_latch_data;
   wire  [7:0]  external_interrupt_input, fast_interrupt_input;
   int          n_errors = 0;
   int          num_checks = 0;
   logic [31:0] rv;
   logic        re;
   always #50 pclk = ~pclk;
   ccpp_port_pins DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .p2_pin_in, .p2_pin_out, .p2_pin_oe, .p3_pin_in, .p3_pin_out,
      .p3_pin_oe, .cc_trigger, .cc_toggle_mode, .cc_overflow, .capture_compare_channel_pin,
      .cc_latch_data, .timer_seven_count_input, .external_interrupt_input,
      .external_interrupt_edge(), .fast_interrupt_input, .fast_interrupt_edge());
   ccpp_partner u_pa (.pclk, .pin_out(p2_pin_out), .pin_oe(p2_pin_oe), .ext_en(e2_en),
      .ext_val(e2_val), .pin_in(p2_pin_in));
   ccpp_partner u_pb (.pclk, .pin_out(p3_pin_out), .pin_oe(p3_pin_oe), .ext_en(e3_en),
      .ext_val(e3_val), .pin_in(p3_pin_in));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   function automatic logic [17:0] ba(input logic [15:0] i);
      return {i, 2'h0};
   endfunction
   // one apb transfer; tm raises compare triggers during the access phase
   task automatic apb(input logic w, input logic [17:0] a, input logic [15:0] d,
                      input logic [15:0] tm);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {16'h0, d};
      @(posedge pclk);
      penable    <= 1'b1;
      cc_trigger <= tm;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rv = prdata;
      re = pslverr;
      psel       <= 1'b0;
      penable    <= 1'b0;
      cc_trigger <= 16'h0;
      if (k == 16) begin
         n_errors++;
         wrap_up();
      end
      @(negedge pclk); // let register updates land before looking
   endtask
   task automatic wr(input logic [15:0] i, input logic [15:0] d);
      apb(1'b1, ba(i), d, 16'h0);
   endtask
   task automatic rd(input string nm, input logic [15:0] i, input logic [31:0] x);
      apb(1'b0, ba(i), 16'h0, 16'h0);
      chk(nm, rv, x);
   endtask
   task automatic t_reset;
      logic [15:0] ix [6];
      ix = '{`CCPP_IDX_P2_DATA, `CCPP_IDX_P2_DIR, `CCPP_IDX_P2_OD,
             `CCPP_IDX_P3_DATA, `CCPP_IDX_P3_DIR, `CCPP_IDX_P3_OD};
      chk("oe at reset", {p2_pin_oe, p3_pin_oe}, 32'h0);
      foreach (ix[i]) rd("reset value", ix[i], 32'h0);
      $display("test reset done");
   endtask
   task automatic t_port3;
      wr(`CCPP_IDX_P3_DIR, 16'hffff);
      rd("dir3", `CCPP_IDX_P3_DIR, 32'hbfff);
      wr(`CCPP_IDX_P3_OD, 16'hffff);
      rd("od3", `CCPP_IDX_P3_OD, 32'h2fff);
      wr(`CCPP_IDX_P3_DATA, 16'hffff);
      rd("data3", `CCPP_IDX_P3_DATA, 32'hbfff);
      chk("oe3 released", 32'(p3_pin_oe), 32'h9000);
      wr(`CCPP_IDX_P3_DATA, 16'h0000);
      chk("oe3 sinking", 32'(p3_pin_oe), 32'hbfff);
      wr(`CCPP_IDX_P3_OD, 16'h0000);
      wr(`CCPP_IDX_P3_DATA, 16'h00ff);
      chk("out3 push pull", {p3_pin_oe, p3_pin_out}, 32'hbfff00ff);
      wr(`CCPP_IDX_P3_DIR, 16'h0000);
      chk("oe3 input", 32'(p3_pin_oe), 32'h0);
      @(posedge pclk);
      e3_en  <= 16'hffff;
      e3_val <= 16'h1234;
      repeat (4) @(posedge pclk);
      rd("pin3", `CCPP_IDX_P3_PIN, 32'h1234);
      rd("unmapped", 16'h0005, 32'h0);
      chk("unmapped error", 32'(re), 32'h1);
      apb(1'b1, ba(`CCPP_IDX_P3_DIR) | 18'h2, 16'hffff, 16'h0);
      rd("misaligned ignored", `CCPP_IDX_P3_DIR, 32'h0);
      $display("test port3 done");
   endtask
   task automatic t_compare;
      @(posedge pclk);
      cc_toggle_mode <= 16'hffff;
      wr(`CCPP_IDX_P2_DIR, 16'hffff);
      wr(`CCPP_IDX_P2_DATA, 16'h00f0);
      @(posedge pclk);
      cc_trigger <= 16'h0011;
      @(posedge pclk);
      cc_trigger     <= 16'h0300;
      cc_toggle_mode <= 16'h0000;
      cc_overflow    <= 16'h0100;
      @(negedge pclk);
      chk("toggle", 32'(p2_pin_out), 32'h00e1);
      @(posedge pclk);
      cc_trigger <= 16'h0000;
      @(negedge pclk);
      chk("latch view", 32'(cc_latch_data), 32'h02e1);
      rd("set clear", `CCPP_IDX_P2_DATA, 32'h02e1);
      @(posedge pclk);
      cc_toggle_mode <= 16'hffff;
      apb(1'b1, ba(`CCPP_IDX_P2_DATA), 16'h5555, 16'hffff);
      rd("cpu wins", `CCPP_IDX_P2_DATA, 32'h5555);
      chk("oe2 out", 32'(p2_pin_oe), 32'hffff);
      chk("capture latch", 32'(capture_compare_channel_pin), 32'h5555);
      chk("fast from latch", 32'(fast_interrupt_input), 32'h55);
      wr(`CCPP_IDX_P2_OD, 16'hffff);
      chk("oe2 open drain", 32'(p2_pin_oe), 32'haaaa);
      wr(`CCPP_IDX_P2_DIR, 16'h0000);
      @(posedge pclk);
      e2_en  <= 16'hffff;
      e2_val <= 16'ha5c3;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      chk("capture pin", 32'(capture_compare_channel_pin), 32'ha5c3);
      chk("timer seven", 32'(timer_seven_count_input), 32'h1);
      chk("fast pin", 32'(fast_interrupt_input), 32'ha5);
      repeat (10) @(posedge pclk);
      @(negedge pclk);
      chk("slow pin", 32'(external_interrupt_input), 32'ha5);
      $display("test compare done");
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_port3();
      t_compare();
      wrap_up();
   end
endmodule // capture_compare_port_pins_bench
bind ccpp_port_pins ccpp_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pslverr, .p2_pin_out, .p3_pin_out, .p3_pin_oe, .cc_trigger, .cc_toggle_mode,
   .cc_overflow, .capture_compare_channel_pin, .timer_seven_count_input,
   .external_interrupt_input, .fast_interrupt_input);
`default_nettype wire
